// File: rtl/tocp_defines.svh
`ifndef TOCP_DEFINES_SVH
`define TOCP_DEFINES_SVH
// register byte addresses on the bus
`define TOCP_ADR_TCS 8'h00
`define TOCP_ADR_WRAP 8'h04
`define TOCP_ADR_CNT 8'h08
`define TOCP_ADR_CH_BASE 8'h20
`define TOCP_CH_STRIDE 8'h08
`define TOCP_CH_VAL_OFS 8'h04
// timer_ctrl_stat field positions
`define TOCP_BIT_FLAG 7
`define TOCP_BIT_IE 6
`define TOCP_BIT_HALT 5
`define TOCP_BIT_TRST 4
// reset values
`define TOCP_TCS_RESET 8'h20
`define TOCP_CS_RESET 8'h00
`define TOCP_WRAP_RESET 16'hffff
`define TOCP_VAL_RESET 16'h0000
// prescaler select code with no divided clock behind it
`define TOCP_PS_EXT 3'h7
`endif

// File: rtl/tocp_pkg.sv
package tocp_pkg;
   // classic wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } tocp_wb_req_t;
   // channel control/status byte, bit 7 down to bit 0
   typedef struct packed {
      logic flag;
      logic ie;
      logic msb;
      logic msa;
      logic elsb;
      logic elsa;
      logic tov;
      logic max;
   } tocp_chcs_t;
   // channel pin drive: level and output enable per channel
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] oe;
   } tocp_pins_t;
endpackage

// File: rtl/tocp_timer.sv
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "tocp_defines.svh"
// Operation
// - on compare match the channel sets, clears or inverts its pin
// - a compare match can request an interrupt when its enable is set
// - unbuffered value writes replace the active compare value at once
// - compare request ends the pulse; wrap request ends the period
// - link bit of channel 0 pairs channels 0 and 1 onto pin 0
// - link bit of channel 2 pairs 2 and 3 onto pin 2, frees pin 3
// - lower channel values lead; at each wrap last-written values take over
// - linked pair uses lower control register; upper register and pin unused
// - inactive-channel writes take effect only at the next period start
// - toggle-on-wrap inverts the pin when counter reaches wrap limit
// - pulse runs from wrap to match; compare clears or sets the pin
// - period is wrap limit plus one prescaled clocks
// - link bit wins over unbuffered bit on channel 0 and 2
// - wrap flag sets at wrap to zero; its enable gates the request
// - channel flag sets on every match; its enable gates the request
// - with clear on match, no toggle-on-wrap gives zero duty, with full-duty bit full duty
module tocp_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire tocp_pkg::tocp_wb_req_t wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output tocp_pkg::tocp_pins_t chan_pins_o,
   output logic wrap_irq_o,
   output logic [3:0] chan_irq_o
);
   import tocp_pkg::*;

   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d, rdata;
   logic wr, rd, wr_tcs, rd_tcs;
   logic [3:0] wr_cs, rd_cs, wr_val;
   logic [15:0] cnt_q, cnt_d, mod_q, mod_d;
   logic [6:0] presc_q, presc_d, mask;
   logic tick, wrap;
   logic halt_q, halt_d, oie_q, oie_d, wflag_q, wflag_d, warm_q, warm_d;
   logic [2:0] ps_q, ps_d;
   tocp_chcs_t cs_q [4];
   tocp_chcs_t cs_d [4];
   logic [15:0] val_q [4];
   logic [15:0] val_d [4];
   logic [15:0] cmp_w [4];
   logic [3:0] arm_q, arm_d, pin_q, pin_d, oe_q, oe_d, irq_q, irq_d;
   logic [3:0] match_w, oc_w;
   logic [1:0] sel_q, sel_d, last_q, last_d;
   logic wirq_q, wirq_d;

   // bus slave: ack one cycle after the strobe, write and read side
   // effects land on the edge where the master samples ack
   always_comb begin
      ack_d = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
      wr = wb_req_i.cyc & wb_req_i.stb & ack_q & wb_req_i.we;
      rd = wb_req_i.cyc & wb_req_i.stb & ack_q & ~wb_req_i.we;
      wr_tcs = wr & wb_req_i.sel[0] & (wb_req_i.adr == `TOCP_ADR_TCS);
      rd_tcs = rd & (wb_req_i.adr == `TOCP_ADR_TCS);
      rdata = 32'h0000_0000; // unmapped addresses read zero
      case (wb_req_i.adr)
         `TOCP_ADR_TCS: rdata = {24'h00_0000, wflag_q, oie_q, halt_q,
                                 2'b00, ps_q};
         `TOCP_ADR_WRAP: rdata = {16'h0000, mod_q};
         `TOCP_ADR_CNT: rdata = {16'h0000, cnt_q};
         default: begin
            for (int k = 0; k < 4; k++) begin
               if (wb_req_i.adr == 8'(`TOCP_ADR_CH_BASE
                                      + `TOCP_CH_STRIDE * k)) begin
                  rdata = {24'h00_0000, cs_q[k]};
               end
               if (wb_req_i.adr == 8'(`TOCP_ADR_CH_BASE
                      + `TOCP_CH_STRIDE * k + `TOCP_CH_VAL_OFS)) begin
                  rdata = {16'h0000, val_q[k]};
               end
            end
         end
      endcase
      dat_d = ack_d ? rdata : dat_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // prescaler and wrap counter; select 7 has no clock here and stalls
   always_comb begin
      mask = 7'((7'h01 << ps_q) - 7'h01);
      tick = ~halt_q & (ps_q != `TOCP_PS_EXT) & ((presc_q & mask) == mask);
      wrap = tick & (cnt_q == mod_q);
      presc_d = 7'(presc_q + 7'h01);
      cnt_d = cnt_q;
      if (wrap) begin
         cnt_d = 16'h0000;
      end else if (tick) begin
         cnt_d = 16'(cnt_q + 16'h0001);
      end
      if (wr_tcs && wb_req_i.dat[`TOCP_BIT_TRST]) begin
         cnt_d = 16'h0000;
         presc_d = 7'h00;
      end
      mod_d = mod_q;
      if (wr && wb_req_i.adr == `TOCP_ADR_WRAP) begin
         if (wb_req_i.sel[1]) mod_d[15:8] = wb_req_i.dat[15:8];
         if (wb_req_i.sel[0]) mod_d[7:0] = wb_req_i.dat[7:0];
      end
      halt_d = wr_tcs ? wb_req_i.dat[`TOCP_BIT_HALT] : halt_q;
      oie_d = wr_tcs ? wb_req_i.dat[`TOCP_BIT_IE] : oie_q;
      ps_d = wr_tcs ? wb_req_i.dat[2:0] : ps_q;
      // flag clears only by read-while-set then write zero; a wrap in
      // the clearing cycle keeps it set so no request is lost
      warm_d = warm_q;
      if (rd_tcs && wflag_q) warm_d = 1'b1;
      if (wr_tcs) warm_d = 1'b0;
      if (wrap) warm_d = 1'b0; // a fresh wrap voids the pending clear
      wflag_d = wflag_q;
      if (wr_tcs && !wb_req_i.dat[`TOCP_BIT_FLAG] && warm_q) begin
         wflag_d = 1'b0;
      end
      if (wrap) wflag_d = 1'b1;
      wirq_d = wflag_q & oie_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_q <= 7'h00;
         cnt_q <= 16'h0000;
         mod_q <= `TOCP_WRAP_RESET;
         halt_q <= 1'(`TOCP_TCS_RESET >> `TOCP_BIT_HALT);
         oie_q <= 1'b0;
         ps_q <= 3'h0;
         wflag_q <= 1'b0;
         warm_q <= 1'b0;
         wirq_q <= 1'b0;
      end else begin
         presc_q <= presc_d;
         cnt_q <= cnt_d;
         mod_q <= mod_d;
         halt_q <= halt_d;
         oie_q <= oie_d;
         ps_q <= ps_d;
         wflag_q <= wflag_d;
         warm_q <= warm_d;
         wirq_q <= wirq_d;
      end
   end

   // per channel compare, pin action, flag and pair buffering
   for (genvar i = 0; i < 4; i++) begin : g_ch
      localparam int LO = i - (i % 2);
      localparam logic [7:0] CS_ADR =
         8'(`TOCP_ADR_CH_BASE + `TOCP_CH_STRIDE * i);
      localparam logic [7:0] VAL_ADR = 8'(CS_ADR + `TOCP_CH_VAL_OFS);
      logic linked;

      always_comb begin
         wr_cs[i] = wr & wb_req_i.sel[0] & (wb_req_i.adr == CS_ADR);
         rd_cs[i] = rd & (wb_req_i.adr == CS_ADR);
         wr_val[i] = wr & (wb_req_i.adr == VAL_ADR);
         linked = cs_q[LO].msb;
         // upper channel of a linked pair is idle and its pin released
         if (i % 2 == 1) begin
            oc_w[i] = cs_q[i].msa & ~linked;
            cmp_w[i] = val_q[i];
         end else begin
            oc_w[i] = cs_q[i].msb | cs_q[i].msa;
            cmp_w[i] = (linked && sel_q[i / 2]) ? val_q[LO + 1]
                                                : val_q[i];
         end
         match_w[i] = tick & (cmp_w[i] == cnt_q) & oc_w[i];
         cs_d[i] = cs_q[i];
         if (wr_cs[i]) begin
            cs_d[i] = tocp_chcs_t'({cs_q[i].flag, wb_req_i.dat[6:0]});
            if (i % 2 == 1) cs_d[i].msb = 1'b0; // link bit only on 0, 2
         end
         arm_d[i] = arm_q[i];
         if (rd_cs[i] && cs_q[i].flag) arm_d[i] = 1'b1;
         if (wr_cs[i]) arm_d[i] = 1'b0;
         if (wr_cs[i] && !wb_req_i.dat[`TOCP_BIT_FLAG] && arm_q[i]) begin
            cs_d[i].flag = 1'b0;
         end
         if (match_w[i]) cs_d[i].flag = 1'b1;
         val_d[i] = val_q[i];
         if (wr_val[i]) begin
            if (wb_req_i.sel[1]) val_d[i][15:8] = wb_req_i.dat[15:8];
            if (wb_req_i.sel[0]) val_d[i][7:0] = wb_req_i.dat[7:0];
         end
         // toggle first, a match on the same tick overrides it
         pin_d[i] = pin_q[i];
         if (wrap && cs_q[i].tov && oc_w[i]) pin_d[i] = ~pin_q[i];
         if (match_w[i]) begin
            case ({cs_q[i].elsb, cs_q[i].elsa})
               2'b01: pin_d[i] = ~pin_q[i];
               2'b10: pin_d[i] = 1'b0;
               2'b11: pin_d[i] = 1'b1;
               default: pin_d[i] = pin_q[i];
            endcase
         end
         if (oc_w[i] && cs_q[i].max && !cs_q[i].tov && cs_q[i].elsb) begin
            pin_d[i] = ~cs_q[i].elsa;
         end
         oe_d[i] = oc_w[i] & (cs_q[i].elsb | cs_q[i].elsa);
         irq_d[i] = cs_q[i].flag & cs_q[i].ie;
      end

      // active-register select swaps only at wrap, so a write to the
      // idle channel never cuts into the running period
      if (i % 2 == 0) begin : g_pair
         always_comb begin
            last_d[i / 2] = last_q[i / 2];
            sel_d[i / 2] = sel_q[i / 2];
            if (!linked) begin
               last_d[i / 2] = 1'b0;
               sel_d[i / 2] = 1'b0;
            end else begin
               if (wr_val[i]) last_d[i / 2] = 1'b0;
               if (wr_val[i + 1]) last_d[i / 2] = 1'b1;
               if (wrap) sel_d[i / 2] = last_q[i / 2];
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cs_q[i] <= `TOCP_CS_RESET;
            val_q[i] <= `TOCP_VAL_RESET;
            arm_q[i] <= 1'b0;
            pin_q[i] <= 1'b0;
            oe_q[i] <= 1'b0;
            irq_q[i] <= 1'b0;
         end else begin
            cs_q[i] <= cs_d[i];
            val_q[i] <= val_d[i];
            arm_q[i] <= arm_d[i];
            pin_q[i] <= pin_d[i];
            oe_q[i] <= oe_d[i];
            irq_q[i] <= irq_d[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_q <= 2'b00;
         last_q <= 2'b00;
      end else begin
         sel_q <= sel_d;
         last_q <= last_d;
      end
   end

   // outputs straight from flip-flops
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign chan_pins_o = '{level: pin_q, oe: oe_q};
   assign wrap_irq_o = wirq_q;
   assign chan_irq_o = irq_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   cmp_set_a: assert property (
      match_w[0] && cs_q[0].elsb && cs_q[0].elsa && !cs_q[0].max
      |=> chan_pins_o.level[0]) else $error("compare set missed");
   cmp_clear_a: assert property (
      match_w[0] && cs_q[0].elsb && !cs_q[0].elsa && !cs_q[0].max
      |=> !chan_pins_o.level[0]) else $error("compare clear missed");
   chan_flag_a: assert property (
      match_w[1] |=> cs_q[1].flag ##1 chan_irq_o[1] == cs_q[1].ie)
      else $error("channel flag or request wrong");
   chan_irq_a: assert property (
      !cs_q[0].ie |=> !chan_irq_o[0]) else $error("masked request seen");
   wrap_flag_a: assert property (
      wrap && !wr_tcs |=> wflag_q && cnt_q == 16'h0000)
      else $error("wrap flag not set at wrap");
   wrap_irq_a: assert property (
      wflag_q && oie_q |=> wrap_irq_o) else $error("wrap request missing");
   wrap_toggle_a: assert property (
      wrap && cs_q[2].tov && oc_w[2] && !match_w[2] && !cs_q[2].max
      |=> chan_pins_o.level[2] != $past(chan_pins_o.level[2]))
      else $error("no toggle at wrap");
   period_a: assert property (
      tick && !wr_tcs |=> cnt_q == (($past(cnt_q) == $past(mod_q))
         ? 16'h0000 : 16'($past(cnt_q) + 16'h0001)))
      else $error("counter step wrong");
   link_swap_a: assert property (
      wrap && cs_q[0].msb |=> sel_q[0] == $past(last_q[0]))
      else $error("pair did not swap at wrap");
   no_mid_swap_a: assert property (
      cs_q[0].msb && !wrap |=> sel_q[0] == $past(sel_q[0]))
      else $error("pair swapped mid period");
   upper_free_a: assert property (
      cs_q[2].msb |=> !chan_pins_o.oe[3]) else $error("pin 3 still driven");
   unbuf_write_a: assert property (
      wr_val[0] && wb_req_i.sel[1:0] == 2'b11 && !cs_q[0].msb
      |=> cmp_w[0] == $past(wb_req_i.dat[15:0]))
      else $error("unbuffered value not immediate");
   full_duty_a: assert property (
      oc_w[0] && cs_q[0].max && !cs_q[0].tov && cs_q[0].elsb
      |=> chan_pins_o.level[0] == !$past(cs_q[0].elsa))
      else $error("full duty level wrong");
endmodule

// File: tb/tocp_timer_tb_top.sv
`timescale 1ns/1ps
`include "tocp_defines.svh"
module tocp_timer_tb_top;
   import tocp_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   tocp_wb_req_t wb_req_i = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   tocp_pins_t chan_pins_o;
   logic wrap_irq_o;
   logic [3:0] chan_irq_o;
   int n_mismatch = 0;
   int n_checks = 0;
   int lim, ps, hi, per, h1, h2, v1, v2;
   logic [31:0] rd;

   tocp_timer i_tocp_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_req_i(wb_req_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .chan_pins_o(chan_pins_o),
      .wrap_irq_o(wrap_irq_o),
      .chan_irq_o(chan_irq_o)
   );

   // 50 mhz bus clock
   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic results();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one classic cycle; the request stands until ack is sampled,
   // a missing ack is left to the watchdog
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_req_i <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hf, dat:d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) begin
         @(posedge clk_i);
      end
      q = wb_dat_o;
      wb_req_i <= '0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   function automatic logic [7:0] cs(input int ch);
      return `TOCP_ADR_CH_BASE + 8'(ch) * `TOCP_CH_STRIDE;
   endfunction

   // halt and clear first so the new setup starts on a clean period
   task automatic cfg(input int ch, input int v, input logic [7:0] c);
      wr(`TOCP_ADR_TCS, 32'h30);
      wr(`TOCP_ADR_WRAP, 32'(lim));
      wr(cs(ch) + `TOCP_CH_VAL_OFS, 32'(v));
      wr(cs(ch), {24'h0, c});
      wr(`TOCP_ADR_TCS, 32'(ps));
   endtask

   // first pass finds a rising edge, second counts one whole period
   task automatic meas(input int ch);
      logic p;
      for (int k = 0; k < 2; k++) begin
         hi = 0;
         per = 0;
         p = 1'b1;
         while (!(p === 1'b0 && chan_pins_o.level[ch] === 1'b1)) begin
            if (chan_pins_o.level[ch] === 1'b1) begin
               hi++;
            end
            p = chan_pins_o.level[ch];
            per++;
            @(posedge clk_i);
         end
      end
   endtask

   // watchdog sized well past the whole sequence
   initial begin
      #(20 * 60000);
      n_mismatch++;
      results();
   end

   initial begin
      rd = $urandom(32'h0f01);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `TOCP_ADR_TCS, '0, rd);
      chk(rd, 32'h20);
      wb(1'b0, `TOCP_ADR_WRAP, '0, rd);
      chk(rd, 32'hffff);
      wr(8'h80, 32'h1234);
      wb(1'b0, 8'h80, '0, rd);
      chk(rd, 32'h0);
      // unbuffered pwm on every channel, random limit, value and divider
      for (int ch = 0; ch < 4; ch++) begin
         lim = 12 + $urandom % 20;
         ps = $urandom % 3;
         v1 = 3 + $urandom % (lim - 4);
         v2 = 3 + $urandom % (lim - 4);
         cfg(ch, v1, 8'h5a);
         meas(ch);
         chk(per, (lim + 1) << ps);
         h1 = hi;
         // shorter width goes in after the compare, longer before it
         while (chan_pins_o.level[ch] !== (v2 > v1)) begin
            @(posedge clk_i);
         end
         wr(cs(ch) + `TOCP_CH_VAL_OFS, 32'(v2));
         meas(ch);
         h2 = hi;
         chk(h1 - h2, (v1 - v2) << ps);
         chk(chan_pins_o.oe[ch], 1);
         chk(chan_irq_o[ch], 1);
         wr(cs(ch), 32'h5e);
         meas(ch);
         chk(per - hi, h2);
         wr(cs(ch), 32'h54);
         meas(ch);
         chk(per, (2 * lim + 2) << ps);
         chk(hi, (lim + 1) << ps);
         // halted so no new match races the clearing sequence
         wr(`TOCP_ADR_TCS, 32'h20);
         wb(1'b0, cs(ch), '0, rd);
         chk(rd[7], 1);
         wr(cs(ch), rd & 32'h7f);
         repeat (3) @(posedge clk_i);
         chk(chan_irq_o[ch], 0);
      end
      // zero duty, then full duty
      lim = 20;
      ps = 0;
      cfg(0, 5, 8'h18);
      repeat (50) @(posedge clk_i);
      h1 = 0;
      repeat (42) begin
         @(posedge clk_i);
         h1 += int'(chan_pins_o.level[0] === 1'b1);
      end
      chk(h1, 0);
      wr(cs(0), 32'h19);
      repeat (4) @(posedge clk_i);
      chk(chan_pins_o.level[0], 1);
      // select 7 has no clock behind it, so the counter must stand
      wr(`TOCP_ADR_TCS, 32'h07);
      wb(1'b0, `TOCP_ADR_CNT, '0, rd);
      h1 = rd;
      repeat (5) @(posedge clk_i);
      wb(1'b0, `TOCP_ADR_CNT, '0, rd);
      chk(rd, h1);
      // wrap request raised, then cleared while halted so no wrap
      // can land inside the read-then-write clearing sequence
      wr(`TOCP_ADR_TCS, 32'h40);
      repeat (30) @(posedge clk_i);
      chk(wrap_irq_o, 1);
      wr(`TOCP_ADR_TCS, 32'h60);
      wb(1'b0, `TOCP_ADR_TCS, '0, rd);
      chk(rd, 32'he0);
      wr(`TOCP_ADR_TCS, 32'h60);
      repeat (3) @(posedge clk_i);
      chk(wrap_irq_o, 0);
      // linked pairs; link and unbuffered bits both set
      lim = 30;
      for (int p = 0; p < 4; p += 2) begin
         v1 = 8 + $urandom % 10;
         v2 = 8 + $urandom % 10;
         cfg(p, v1, 8'h3a);
         chk(chan_pins_o.oe[p + 1], 0);
         meas(p);
         h1 = hi;
         wr(cs(p + 1) + `TOCP_CH_VAL_OFS, 32'(v2));
         meas(p);
         chk(h1 - hi, v1 - v2);
         wr(cs(p) + `TOCP_CH_VAL_OFS, 32'(v1));
         meas(p);
         chk(hi, h1);
      end
      results();
   end
endmodule
